//--- sleep_pkg.sv
// Package of constants and types for the sleep-mode controller.
// How it works
// RQ1: Sleep is entered only when sleep enable is set and halt executes, kind selects mode.
// RQ2: Enabled interrupt wakes; core held four cycles past start-up, then resumes after halt.
// RQ3: Register file and RAM keep contents; controller only gates clocks, never resets them.
// RQ4: Any reset during sleep wakes the device and restarts from the reset vector.
// RQ5: Requested brown-out shutdown takes effect right after sleep entry, eligible modes only.
// RQ6: Every wake-up switches the brown-out detector back on.
// RQ7: Wake-up delay stretches to about 60 us if the detector was off.
// RQ8: Brown-out shutdown is bit 6 of core control register, reset zero.
// RQ9: Brown-out shutdown bit writes accepted only inside a timed unlock window.
// RQ10: Kind 000 idle stops only CPU and flash clocks; the code also stops the timer 2 clocks that timer 2 does not use.
// RQ11: Idle wakes on external and internal interrupts.
// RQ12: Idle and converter quiet state auto-start an enabled conversion on entry.
// RQ13: Kind 001 stops I/O, CPU and flash clocks; converter and async logic run.
// RQ14: Converter quiet state wakes only on its listed sources.
// RQ15: Kind 010 power-down stops oscillator and all generated clocks.
// RQ16: Power-down wakes only on resets, address match, level group, ext pins, pin change.
// RQ17: External interrupt zero wakes deep modes only in level-sensitive form.
// RQ18: Power-down wake waits a start-up delay chosen by clock source fuses.
// RQ19: Kind 011 power-save is power-down with enabled timer 2 running.
// RQ20: Power-save wakes on timer 2 events only with their mask and global enable set.
// RQ21: Power-save stops unused timer 2 clock sources; sync clock feeds timer 2 only.
// RQ22: Kind 110 standby is power-down with oscillator running, six-cycle wake.
// RQ23: Kind 111 extended standby is power-save with oscillator running, six-cycle wake.
// RQ24: Sleep kind is bits 3 to 1 of sleep control register; 100 and 101 reserved.
// RQ25: Clock gates switch glitch-free, only whole periods reach gated logic.
package sleep_pkg;
    localparam int SLEEP_ENABLE_BIT = 0;
    localparam int KIND_LSB = 1;
    localparam int BOD_OFF_BIT = 6;
    localparam int BOD_UNLOCK_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int UNLOCK_CYCLES = 4;
    localparam int HALT_EXTRA_CYCLES = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int CLK_MHZ = 40;
    localparam int BOD_WAKE_US = 60;
    localparam int BOD_WAKE_CYCLES = BOD_WAKE_US * CLK_MHZ;
    typedef enum logic [2:0] {
        KIND_IDLE = 3'h0,
        KIND_QUIET = 3'h1,
        KIND_PDOWN = 3'h2,
        KIND_PSAVE = 3'h3,
        KIND_STBY = 3'h6,
        KIND_XSTBY = 3'h7
    } sleep_kind_t;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_START = 4'h4,
        ST_HOLD = 4'h8
    } sleep_state_t;
endpackage

//--- clock_gate.sv
// Glitch-free latch-free clock enable cell for one gated domain.
`timescale 1ns/1ps
module clock_gate (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    output logic gate_en_ff
);
    // Enable changes on the falling edge so the gated clock never has runt pulses.
    always_ff @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_en_ff <= 1'b1;
        end else begin
            gate_en_ff <= run; // RQ25
        end
    end
endmodule

//--- sleep_mode_controller.sv
// Sleep-mode controller: mode select, clock gating, wake logic and brown-out control.
`timescale 1ns/1ps
module sleep_mode_controller import sleep_pkg::*; #(
    parameter int START_CYCLES = 64,
    parameter int BOD_WAKE = BOD_WAKE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] sleep_control_reg,
    input wire logic ctrl_we,
    input wire logic [7:0] core_ctrl_wdata,
    input wire logic core_ctrl_we,
    input wire logic halt_exec,
    input wire logic any_reset_req,
    input wire logic global_irq_en,
    input wire logic [1:0] timer2_irq_mask,
    input wire logic timer2_async,
    input wire logic timer2_sync,
    input wire logic timer2_en,
    input wire logic adc_enabled,
    input wire logic [2:0] ext_irq_pins,
    input wire logic ext_irq_zero_level,
    input wire logic pin_change,
    input wire logic pin_change_group,
    input wire logic twi_match,
    input wire logic twi_irq,
    input wire logic wdt_event,
    input wire logic adc_done,
    input wire logic spm_ready,
    input wire logic [1:0] timer2_events,
    input wire logic internal_irq,
    output logic [7:0] core_control_reg_ff,
    output logic cpu_clk_en_ff,
    output logic flash_clk_en_ff,
    output logic io_clk_en_ff,
    output logic adc_clk_en_ff,
    output logic main_osc_en_ff,
    output logic timer_osc_en_ff,
    output logic timer2_sync_clk_en_ff,
    output logic brownout_detector_en_ff,
    output logic adc_start_ff,
    output logic core_hold_ff,
    output logic restart_vector_ff,
    output logic sleeping_ff
);
    sleep_state_t state_ff;
    sleep_state_t nxt_state;
    logic [2:0] kind_ff;
    logic [2:0] unlock_cnt_ff;
    logic bod_was_off_ff;
    logic reset_wake_ff;
    logic [15:0] wait_cnt_ff;
    logic [15:0] nxt_wait;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] ext_s1_ff;
    logic [2:0] ext_s2_ff;
    logic wake;
    logic cpu_run;
    logic cpu_gate;

    // Deep modes stop the oscillator, except power-save with sync timer 2, and get the start-up delay.
    function automatic logic deep_kind(input logic [2:0] k);
        deep_kind = (k == KIND_PDOWN) || (k == KIND_PSAVE);
    endfunction

    // Brown-out shutdown is only allowed in power-down, save and both standbys.
    function automatic logic bod_ok(input logic [2:0] k);
        bod_ok = (k != KIND_IDLE) && (k != KIND_QUIET) && (k[2:1] != 2'b10);
    endfunction

    // Wake pins from outside pass two flip-flops before any logic looks at them.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            ext_s1_ff <= 3'h0;
            ext_s2_ff <= 3'h0;
        end else begin
            sync1_ff <= {pin_change, pin_change_group, ext_irq_zero_level};
            sync2_ff <= sync1_ff;
            ext_s1_ff <= ext_irq_pins;
            ext_s2_ff <= ext_s1_ff;
        end
    end

    // Wake decode per kind; ext pin zero counts in deep modes only as level form.
    always_comb begin
        wake = 1'b0;
        case (kind_ff)
            KIND_IDLE: wake = internal_irq | (|ext_s2_ff) | (|sync2_ff); // RQ11
            KIND_QUIET: wake = adc_done | wdt_event | twi_irq | (|timer2_events) | spm_ready
                             | sync2_ff[1] | sync2_ff[2] | sync2_ff[0]; // RQ14
            KIND_PDOWN, KIND_STBY: wake = wdt_event | twi_match | sync2_ff[1] | sync2_ff[2]
                             | (|ext_s2_ff[2:1]) | sync2_ff[0]; // RQ16 RQ17
            KIND_PSAVE, KIND_XSTBY: wake = wdt_event | twi_match | sync2_ff[1] | sync2_ff[2]
                             | (|ext_s2_ff[2:1]) | sync2_ff[0] // RQ19 RQ17
                             | (global_irq_en & |(timer2_events & timer2_irq_mask)); // RQ20
            default: wake = 1'b0;
        endcase
    end

    // Unlock window: setting both bits opens it, bit writes count only inside it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_control_reg_ff <= CTRL_RESET; // RQ8
            unlock_cnt_ff <= 3'h0;
        end else begin
            if (core_ctrl_we && core_ctrl_wdata[BOD_OFF_BIT] && core_ctrl_wdata[BOD_UNLOCK_BIT]) begin
                unlock_cnt_ff <= 3'(UNLOCK_CYCLES); // RQ9
                core_control_reg_ff[BOD_UNLOCK_BIT] <= 1'b1;
            end else if (core_ctrl_we && unlock_cnt_ff != 3'h0) begin
                core_control_reg_ff[BOD_OFF_BIT] <= core_ctrl_wdata[BOD_OFF_BIT]; // RQ9
                core_control_reg_ff[BOD_UNLOCK_BIT] <= 1'b0;
                unlock_cnt_ff <= 3'h0;
            end else if (unlock_cnt_ff != 3'h0) begin
                unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
                if (unlock_cnt_ff == 3'h1) begin
                    core_control_reg_ff[BOD_UNLOCK_BIT] <= 1'b0;
                end
            end
            // Cleared on the last hold cycle, so every new sleep needs a fresh unlock first.
            if (state_ff == ST_HOLD && wait_cnt_ff == 16'h1) begin
                core_control_reg_ff[BOD_OFF_BIT] <= 1'b0;
            end
        end
    end

    // Sequencer next state and wait counts.
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_cnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (halt_exec && sleep_control_reg[SLEEP_ENABLE_BIT]
                    && sleep_control_reg[3:1] != 3'h4 && sleep_control_reg[3:1] != 3'h5) begin
                    nxt_state = ST_SLEEP; // RQ1 RQ24
                end
            end
            ST_SLEEP: begin
                if (any_reset_req || wake) begin
                    nxt_state = ST_START;
                    if (deep_kind(kind_ff)) begin
                        nxt_wait = 16'(START_CYCLES); // RQ18
                    end else if (kind_ff[2]) begin
                        nxt_wait = 16'(STANDBY_WAKE_CYCLES); // RQ22 RQ23
                    end else begin
                        nxt_wait = 16'h0;
                    end
                    if (bod_was_off_ff && nxt_wait < 16'(BOD_WAKE)) begin
                        nxt_wait = 16'(BOD_WAKE); // RQ7
                    end
                end
            end
            ST_START: begin
                if (wait_cnt_ff <= 16'h1) begin
                    nxt_state = ST_HOLD;
                    nxt_wait = 16'(HALT_EXTRA_CYCLES); // RQ2
                end else begin
                    nxt_wait = wait_cnt_ff - 16'h1;
                end
            end
            ST_HOLD: begin
                if (wait_cnt_ff <= 16'h1) begin
                    nxt_state = ST_RUN;
                    nxt_wait = 16'h0;
                end else begin
                    nxt_wait = wait_cnt_ff - 16'h1;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    // State register; wake only gates clocks, so memories keep their contents.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_RUN;
            wait_cnt_ff <= 16'h0;
        end else begin
            state_ff <= nxt_state; // RQ3
            wait_cnt_ff <= nxt_wait;
        end
    end

    // Mode capture, brown-out and reset-wake bookkeeping.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            kind_ff <= 3'h0;
            bod_was_off_ff <= 1'b0;
            reset_wake_ff <= 1'b0;
            brownout_detector_en_ff <= 1'b1;
        end else begin
            if (state_ff == ST_RUN && nxt_state == ST_SLEEP) begin
                kind_ff <= sleep_control_reg[3:1];
                reset_wake_ff <= 1'b0;
                if (core_control_reg_ff[BOD_OFF_BIT] && bod_ok(sleep_control_reg[3:1])) begin
                    brownout_detector_en_ff <= 1'b0; // RQ5
                    bod_was_off_ff <= 1'b1;
                end else begin
                    bod_was_off_ff <= 1'b0;
                end
            end
            if (state_ff == ST_SLEEP && nxt_state == ST_START) begin
                brownout_detector_en_ff <= 1'b1; // RQ6
                reset_wake_ff <= any_reset_req; // RQ4
            end
        end
    end

    assign cpu_run = (state_ff == ST_RUN);
    clock_gate u_cpu_gate (
        .clk(clk),
        .arst_n(arst_n),
        .run(cpu_run),
        .gate_en_ff(cpu_gate)
    );

    // Clock domain enables per mode; registered, gate cell keeps CPU clean.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_en_ff <= 1'b1;
            flash_clk_en_ff <= 1'b1;
            io_clk_en_ff <= 1'b1;
            adc_clk_en_ff <= 1'b1;
            main_osc_en_ff <= 1'b1;
            timer_osc_en_ff <= 1'b1;
            timer2_sync_clk_en_ff <= 1'b1;
            adc_start_ff <= 1'b0;
            core_hold_ff <= 1'b0;
            restart_vector_ff <= 1'b0;
            sleeping_ff <= 1'b0;
        end else begin
            cpu_clk_en_ff <= cpu_gate; // RQ25 RQ10
            flash_clk_en_ff <= cpu_gate; // RQ10
            sleeping_ff <= (state_ff == ST_SLEEP);
            core_hold_ff <= (state_ff != ST_RUN);
            restart_vector_ff <= (state_ff == ST_HOLD) && reset_wake_ff; // RQ4
            adc_start_ff <= (state_ff == ST_RUN) && (nxt_state == ST_SLEEP) && adc_enabled
                            && (sleep_control_reg[3:1] == KIND_IDLE
                            || sleep_control_reg[3:1] == KIND_QUIET); // RQ12
            if (state_ff == ST_SLEEP) begin
                io_clk_en_ff <= (kind_ff == KIND_IDLE); // RQ13
                adc_clk_en_ff <= (kind_ff == KIND_IDLE) || (kind_ff == KIND_QUIET); // RQ15
                main_osc_en_ff <= !deep_kind(kind_ff)
                                  || (kind_ff == KIND_PSAVE && timer2_en && timer2_sync); // RQ21
                timer_osc_en_ff <= timer2_async && (kind_ff != KIND_PDOWN)
                                   && (kind_ff != KIND_STBY); // RQ21
                timer2_sync_clk_en_ff <= timer2_en && timer2_sync
                                         && (kind_ff == KIND_PSAVE || kind_ff[2:1] != 2'b01);
            end else begin
                io_clk_en_ff <= 1'b1;
                adc_clk_en_ff <= 1'b1;
                main_osc_en_ff <= 1'b1;
                timer_osc_en_ff <= 1'b1;
                timer2_sync_clk_en_ff <= 1'b1;
            end
        end
    end

    // Checks on the sequencer, the clock gates and the brown-out control.
    a_sleep_entry: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
        (state_ff == ST_RUN && halt_exec && !sleep_control_reg[SLEEP_ENABLE_BIT])
        |=> state_ff == ST_RUN) else $error("sleep without enable");
    a_hold_four: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
        (state_ff == ST_START && nxt_state == ST_HOLD) |=> (state_ff == ST_HOLD)[*4]
        ##1 state_ff == ST_RUN) else $error("hold not four cycles");
    a_bod_wake_on: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
        (state_ff == ST_SLEEP && nxt_state == ST_START) |=> brownout_detector_en_ff)
        else $error("detector not restored");
    a_bod_off_ok: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
        !brownout_detector_en_ff |-> bod_ok(kind_ff) && state_ff == ST_SLEEP)
        else $error("detector off in wrong mode");
    // A detector that was off must get at least its full settling time before code runs.
    a_bod_long: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
        (state_ff == ST_SLEEP && nxt_state == ST_START && bod_was_off_ff)
        |=> wait_cnt_ff >= 16'(BOD_WAKE))
        else $error("wake count too short");
    a_reset_wake: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
        (state_ff == ST_SLEEP && any_reset_req) |=> state_ff == ST_START)
        else $error("reset did not wake");
    a_idle_clocks: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
        (state_ff == ST_SLEEP && kind_ff == KIND_IDLE) |=> io_clk_en_ff)
        else $error("idle stopped io clock");
    a_quiet_io: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
        (state_ff == ST_SLEEP && $past(state_ff) == ST_SLEEP && kind_ff == KIND_QUIET)
        |=> !io_clk_en_ff && adc_clk_en_ff) else $error("quiet clocks wrong");
    a_pdown_osc: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
        (state_ff == ST_SLEEP && kind_ff == KIND_PDOWN) |=> !main_osc_en_ff)
        else $error("oscillator left on");
    // Once the gate has had a cycle to close, the core and flash clocks stay off in sleep.
    a_cpu_gated: assert property (@(posedge clk) disable iff (!arst_n) // RQ10 RQ25
        (state_ff == ST_SLEEP && $past(state_ff) == ST_SLEEP)
        |-> !cpu_clk_en_ff && !flash_clk_en_ff)
        else $error("core clock running in sleep");
    a_adc_autostart: assert property (@(posedge clk) disable iff (!arst_n) // RQ12
        (state_ff == ST_RUN && nxt_state == ST_SLEEP && adc_enabled
        && sleep_control_reg[3:1] == KIND_QUIET) |=> adc_start_ff)
        else $error("conversion not started");
    // Outside the window and outside the wake hold, the shutdown bit must not move.
    a_bod_locked: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
        (unlock_cnt_ff == 3'h0 && state_ff != ST_HOLD)
        |=> $stable(core_control_reg_ff[BOD_OFF_BIT]))
        else $error("shutdown bit changed while locked");
endmodule

//--- core_model.sv
// Processor-core model that programs the sleep controls and issues the halt instruction.
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    output logic [7:0] sleep_control_reg,
    output logic ctrl_we,
    output logic [7:0] core_ctrl_wdata,
    output logic core_ctrl_we,
    output logic halt_exec
);
    // The core starts quiet, with no sleep request and no control write.
    initial begin
        sleep_control_reg = 8'h00;
        ctrl_we = 1'b0;
        core_ctrl_wdata = 8'h00;
        core_ctrl_we = 1'b0;
        halt_exec = 1'b0;
    end
    // Enable and kind settle a cycle before the halt, so both are seen together.
    task automatic sleep_cmd(input logic [2:0] kind, input logic en);
        @(negedge clk);
        sleep_control_reg <= {4'h0, kind, en};
        ctrl_we <= 1'b1;
        @(negedge clk);
        ctrl_we <= 1'b0;
        halt_exec <= 1'b1;
        @(negedge clk);
        halt_exec <= 1'b0;
    endtask
    // One control write; the data lines are scrambled afterwards so stale data never matches.
    task automatic write_core(input logic [7:0] data);
        @(negedge clk);
        core_ctrl_wdata <= data;
        core_ctrl_we <= 1'b1;
        @(negedge clk);
        core_ctrl_we <= 1'b0;
        core_ctrl_wdata <= ~data;
    endtask
    // Unlock write, then the real write two cycles later, well inside the four-cycle window.
    task automatic set_brownout_off_in_halt();
        write_core(8'h60);
        write_core(8'h40);
    endtask
endmodule

//--- sleep_mode_controller_test.sv
// Self-checking bench for the sleep-mode controller driven by a core model.
`timescale 1ns/1ps
module sleep_mode_controller_test;
    import sleep_pkg::*;
    localparam int START = 8;
    localparam int BODW = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] src = '0;
    logic adc_en = 1'b1;
    logic gie = 1'b1;
    logic t2sync = 1'b0;
    logic [7:0] sleep_control_reg, core_ctrl_wdata, core_control_reg_ff;
    logic ctrl_we, core_ctrl_we, halt_exec, adc_start_ff, core_hold_ff;
    logic restart_vector_ff, sleeping_ff, cpu_en, flash_en, io_en, adc_clk_en;
    logic osc_en, tosc_en, bod_en, t2s_en;
    logic [6:0] ens;
    int error_cnt = 0;
    int n_compared = 0;
    int adc_starts = 0;
    int rv_seen = 0;
    int cycles = 0;
    assign ens = {cpu_en, flash_en, io_en, adc_clk_en, osc_en, tosc_en, bod_en};
    // Half-period of 12.5 ns gives the 40 MHz system clock.
    always #12.5 clk = ~clk;
    core_model core (.clk(clk), .sleep_control_reg(sleep_control_reg), .ctrl_we(ctrl_we),
        .core_ctrl_wdata(core_ctrl_wdata), .core_ctrl_we(core_ctrl_we), .halt_exec(halt_exec));
    // Short start and brown-out delays keep each wake-up to a few dozen cycles.
    sleep_mode_controller #(.START_CYCLES(START), .BOD_WAKE(BODW)) dut (.clk(clk),
        .arst_n(arst_n), .sleep_control_reg(sleep_control_reg), .ctrl_we(ctrl_we),
        .core_ctrl_wdata(core_ctrl_wdata), .core_ctrl_we(core_ctrl_we), .halt_exec(halt_exec),
        .any_reset_req(src[13]), .global_irq_en(gie), .timer2_irq_mask(2'b01),
        .timer2_async(1'b1), .timer2_sync(t2sync), .timer2_en(1'b1), .adc_enabled(adc_en),
        .ext_irq_pins({src[12], src[14], src[10]}), .ext_irq_zero_level(src[11]),
        .pin_change(src[4]), .pin_change_group(src[5]), .twi_match(src[6]), .twi_irq(src[1]),
        .wdt_event(src[3]), .adc_done(src[0]), .spm_ready(src[2]), .timer2_events(src[9:8]),
        .internal_irq(src[7]), .core_control_reg_ff(core_control_reg_ff), .cpu_clk_en_ff(cpu_en),
        .flash_clk_en_ff(flash_en), .io_clk_en_ff(io_en), .adc_clk_en_ff(adc_clk_en),
        .main_osc_en_ff(osc_en), .timer_osc_en_ff(tosc_en), .timer2_sync_clk_en_ff(t2s_en),
        .brownout_detector_en_ff(bod_en), .adc_start_ff(adc_start_ff),
        .core_hold_ff(core_hold_ff), .restart_vector_ff(restart_vector_ff),
        .sleeping_ff(sleeping_ff));
    // Single-cycle outputs are caught here so no pulse is missed; also cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (adc_start_ff === 1'b1) adc_starts++;
        if (restart_vector_ff === 1'b1) rv_seen = 1;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_cnt(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    // Enter a mode, offer a source that must not wake it, then one that must, and time it.
    task automatic run_mode(input logic [2:0] kind, input logic [6:0] exp_en, input int bad,
            input int good, input int lo, input int hi, input int exp_rv);
        int n;
        int exp_adc;
        exp_adc = (adc_en && kind <= 3'h1) ? 1 : 0;
        adc_starts = 0;
        rv_seen = 0;
        core.sleep_cmd(kind, 1'b1);
        repeat (4) @(negedge clk);
        check_val("sleeping", 8'h01, {7'h0, sleeping_ff});
        check_val("clock enables", {t2sync, exp_en}, {t2s_en, ens});
        src[bad] = 1'b1;
        repeat (12) @(negedge clk);
        check_val("no wake", 8'h01, {7'h0, sleeping_ff});
        src[good] = 1'b1;
        n = 0;
        while (core_hold_ff !== 1'b0 && n < 3000) begin
            @(negedge clk);
            src[13] = 1'b0;
            n++;
        end
        check_cnt("wake cycles", lo, hi, n);
        check_val("detector on", 8'h01, {7'h0, bod_en});
        check_cnt("restart vector", exp_rv, exp_rv, rv_seen);
        check_cnt("adc starts", exp_adc, exp_adc, adc_starts);
        src = '0;
        repeat (2) @(negedge clk);
    endtask
    // Halt without enable and both reserved kinds must leave the core running.
    task automatic refused();
        logic [2:0] k[3] = '{3'h0, 3'h4, 3'h5};
        for (int i = 0; i < 3; i++) begin
            core.sleep_cmd(k[i], i != 0);
            repeat (4) @(negedge clk);
            check_val("refused halt", 8'h00, {7'h0, sleeping_ff});
        end
    endtask
    // The shutdown bit is locked, then ignored in idle, honoured in power-down, and cleared on wake.
    task automatic bod_scenario();
        core.write_core(8'h40);
        check_val("locked write", 8'h00, core_control_reg_ff & 8'h40);
        core.set_brownout_off_in_halt();
        check_val("brownout bit", 8'h40, core_control_reg_ff & 8'h40);
        run_mode(KIND_IDLE, 7'h1f, 15, 7, 4, 11, 0);
        core.set_brownout_off_in_halt();
        run_mode(KIND_PDOWN, 7'h00, 15, 4, BODW + 4, BODW + 14, 0);
        check_val("brownout bit cleared", 8'h00, core_control_reg_ff & 8'h40);
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence: reset values, refusals, every sleep kind, then brown-out handling.
    initial begin
        int pd_src[5] = '{3, 4, 5, 6, 12};
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check_val("reset enables", 8'hff, {t2s_en, ens});
        check_val("core control reset", CTRL_RESET, core_control_reg_ff);
        refused();
        run_mode(KIND_IDLE, 7'h1f, 15, 7, 4, 11, 0);
        for (int i = 0; i < 6; i++) run_mode(KIND_QUIET, 7'h0f, 7, i, 4, 13, 0);
        foreach (pd_src[i]) run_mode(KIND_PDOWN, 7'h01, 0, pd_src[i], START + 4, START + 13, 0);
        run_mode(KIND_PDOWN, 7'h01, 10, 11, START + 4, START + 13, 0);
        run_mode(KIND_PDOWN, 7'h01, 1, 13, 1, 40, 1);
        run_mode(KIND_PSAVE, 7'h03, 9, 8, START + 4, START + 13, 0);
        // Global enable off: an unmasked timer event must not wake; sync timer clock keeps main source.
        gie = 1'b0;
        t2sync = 1'b1;
        run_mode(KIND_PSAVE, 7'h07, 8, 6, START + 4, START + 13, 0);
        gie = 1'b1;
        t2sync = 1'b0;
        adc_en = 1'b0;
        run_mode(KIND_STBY, 7'h05, 2, 4, STANDBY_WAKE_CYCLES + 4, STANDBY_WAKE_CYCLES + 13, 0);
        run_mode(KIND_XSTBY, 7'h07, 15, 8, STANDBY_WAKE_CYCLES + 4, STANDBY_WAKE_CYCLES + 13, 0);
        adc_en = 1'b1;
        bod_scenario();
        give_verdict();
    end
endmodule
